// file: pkg/bat_pkg.sv
// ============================================================
// Shared constants for back-EMF and calibration timing
package bat_pkg;

  // ==========================================================
  // Clock and time base
  localparam int unsigned CLK_FREQ_HZ = 25_000_000;
  localparam int unsigned US_PER_S = 1_000_000;
  localparam int unsigned MS_PER_S = 1_000;
  localparam int unsigned US_CYCLES = CLK_FREQ_HZ / US_PER_S;
  localparam int unsigned MS_CYCLES = CLK_FREQ_HZ / MS_PER_S;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_BEMF_TIMING = 8'h29;
  localparam logic [7:0] ADDR_CAL_DURATION = 8'h2a;
  localparam logic [7:0] RST_BEMF_TIMING = 8'h0c;
  localparam logic [7:0] RST_CAL_DURATION = 8'h02;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  localparam int unsigned WIN_LSB = 0;
  localparam int unsigned SAMP_LSB = 2;
  localparam int unsigned CAL_LSB = 0;

  // ==========================================================
  // Field decodes in microseconds / milliseconds
  localparam int unsigned SAMP_US_0 = 150;
  localparam int unsigned SAMP_US_1 = 200;
  localparam int unsigned SAMP_US_2 = 250;
  localparam int unsigned SAMP_US_3 = 300;
  localparam int unsigned WIN_US_0 = 100;
  localparam int unsigned WIN_US_1 = 200;
  localparam int unsigned WIN_US_2 = 300;
  localparam int unsigned WIN_US_3 = 390;
  localparam int unsigned CAL_MS_0 = 250;
  localparam int unsigned CAL_MS_1 = 500;
  localparam int unsigned CAL_MS_2 = 1000;
  localparam logic [1:0] CAL_LEN_TRIG = 2'h3;
  localparam int unsigned US_W = 9;
  localparam int unsigned MS_W = 10;

  typedef enum logic [1:0] {
    BAT_IDLE = 2'b00,
    BAT_RUN = 2'b01,
    BAT_MEAS = 2'b10
  } bat_cal_state_t;

  function automatic logic [US_W-1:0] bat_samp_us(input logic [1:0] code);
    case (code)
      2'h0: bat_samp_us = US_W'(SAMP_US_0);
      2'h1: bat_samp_us = US_W'(SAMP_US_1);
      2'h2: bat_samp_us = US_W'(SAMP_US_2);
      default: bat_samp_us = US_W'(SAMP_US_3);
    endcase
  endfunction : bat_samp_us

  function automatic logic [US_W-1:0] bat_win_us(input logic [1:0] code);
    case (code)
      2'h0: bat_win_us = US_W'(WIN_US_0);
      2'h1: bat_win_us = US_W'(WIN_US_1);
      2'h2: bat_win_us = US_W'(WIN_US_2);
      default: bat_win_us = US_W'(WIN_US_3);
    endcase
  endfunction : bat_win_us

  function automatic logic [MS_W-1:0] bat_cal_ms(input logic [1:0] code);
    case (code)
      2'h0: bat_cal_ms = MS_W'(CAL_MS_0);
      2'h1: bat_cal_ms = MS_W'(CAL_MS_1);
      default: bat_cal_ms = MS_W'(CAL_MS_2);
    endcase
  endfunction : bat_cal_ms

endpackage : bat_pkg

// file: src/bat_tick_div.sv
`timescale 1ns/1ps
// ============================================================
// Tick divider: one-cycle enable every DIV cycles, restartable
module bat_tick_div #(
  parameter int unsigned DIV = 25
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic clr_i,
  // Enable pulse
  output logic tick_o
);

  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_q;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || clr_i || tick_o) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  assign tick_o = rst_n_i && !clr_i && (cnt_q == LAST);

endmodule : bat_tick_div

// file: src/bat_timing.sv
`timescale 1ns/1ps
// Summary of operation
// - The two-bit sample-delay field picks 150, 200, 250 or 300 us before the back-EMF sample and resets to code 3.
// - The two-bit crossing window field in bits 1:0 picks 100, 200, 300 or 390 us and resets to 0.
// - The calibration-length field picks 250, 500 or 1000 ms of run time and resets to code 2.
// - In trigger-controlled mode the run ends on the external trigger, the enable input or the software trigger.
// - After the cancelling trigger the device takes its measurements, which may last several ms.
module bat_timing
  import bat_pkg::*;
#(
  parameter int unsigned MS_DIV = MS_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Back-EMF sensing
  input wire logic zc_event_i,
  output logic zc_window_o,
  output logic sample_strobe_o,
  // Calibration control
  input wire logic cal_start_i,
  input wire logic sw_trig_i,
  input wire logic ext_trig_i,
  input wire logic enable_i,
  input wire logic meas_done_i,
  output logic cal_busy_o,
  output logic cal_measure_o,
  output logic cal_done_o
);

  // ==========================================================
  // Registers
  logic [7:0] bemf_timing_q;
  logic [7:0] calibration_duration_ctrl_q;
  logic [1:0] crossing_window_sel;
  logic [1:0] sample_delay_sel;
  logic [1:0] cal_len_sel;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      bemf_timing_q <= RST_BEMF_TIMING;
    end else if (reg_wr_i && reg_addr_i == ADDR_BEMF_TIMING) begin
      bemf_timing_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      calibration_duration_ctrl_q <= RST_CAL_DURATION;
    end else if (reg_wr_i && reg_addr_i == ADDR_CAL_DURATION) begin
      calibration_duration_ctrl_q <= reg_wdata_i;
    end
  end

  assign crossing_window_sel = bemf_timing_q[WIN_LSB +: 2];
  assign sample_delay_sel = bemf_timing_q[SAMP_LSB +: 2];
  assign cal_len_sel = calibration_duration_ctrl_q[CAL_LSB +: 2];

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= RDATA_UNMAPPED;
    end else begin
      case (reg_addr_i)
        ADDR_BEMF_TIMING: reg_rdata_o <= bemf_timing_q;
        ADDR_CAL_DURATION: reg_rdata_o <= calibration_duration_ctrl_q;
        default: reg_rdata_o <= RDATA_UNMAPPED;
      endcase
    end
  end

  // ==========================================================
  // Zero-crossing window and sample delay
  logic us_tick;
  logic [US_W-1:0] win_cnt_q;
  logic [US_W-1:0] samp_cnt_q;

  bat_tick_div #(.DIV(US_CYCLES)) u_us_div (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .clr_i(zc_event_i),
    .tick_o(us_tick)
  );

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      win_cnt_q <= '0;
    end else if (zc_event_i) begin
      win_cnt_q <= bat_win_us(crossing_window_sel);
    end else if (us_tick && win_cnt_q != '0) begin
      win_cnt_q <= win_cnt_q - US_W'(1);
    end
  end

  assign zc_window_o = (win_cnt_q != '0);

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      samp_cnt_q <= '0;
      sample_strobe_o <= 1'b0;
    end else if (zc_event_i) begin
      samp_cnt_q <= bat_samp_us(sample_delay_sel);
      sample_strobe_o <= 1'b0;
    end else begin
      sample_strobe_o <= us_tick && (samp_cnt_q == US_W'(1));
      if (us_tick && samp_cnt_q != '0) begin
        samp_cnt_q <= samp_cnt_q - US_W'(1);
      end
    end
  end

  // ==========================================================
  // Trigger inputs from pins: two-stage sync then edge detect
  logic [1:0] ext_sync_q;
  logic [1:0] en_sync_q;
  logic ext_prev_q;
  logic en_prev_q;
  logic cancel_trig;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ext_sync_q <= 2'h0;
      en_sync_q <= 2'h0;
      ext_prev_q <= 1'b0;
      en_prev_q <= 1'b0;
    end else begin
      ext_sync_q <= {ext_sync_q[0], ext_trig_i};
      en_sync_q <= {en_sync_q[0], enable_i};
      ext_prev_q <= ext_sync_q[1];
      en_prev_q <= en_sync_q[1];
    end
  end

  assign cancel_trig = sw_trig_i || (ext_sync_q[1] && !ext_prev_q) ||
                       (en_sync_q[1] && !en_prev_q);

  // ==========================================================
  // Calibration sequencer
  bat_cal_state_t state_q;
  logic ms_tick;
  logic trig_mode_q;
  logic [MS_W-1:0] ms_cnt_q;
  logic [1:0] cal_code_q;

  bat_tick_div #(.DIV(MS_DIV)) u_ms_div (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .clr_i(cal_start_i && state_q == BAT_IDLE),
    .tick_o(ms_tick)
  );

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_q <= BAT_IDLE;
    end else begin
      case (state_q)
        BAT_IDLE: begin
          if (cal_start_i) begin
            state_q <= BAT_RUN;
          end
        end
        BAT_RUN: begin
          if (trig_mode_q ? cancel_trig : (ms_tick && ms_cnt_q == MS_W'(1))) begin
            state_q <= BAT_MEAS;
          end
        end
        BAT_MEAS: begin
          if (meas_done_i) begin
            state_q <= BAT_IDLE;
          end
        end
        default: state_q <= BAT_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      trig_mode_q <= 1'b0;
      cal_code_q <= 2'h0;
      ms_cnt_q <= '0;
    end else if (cal_start_i && state_q == BAT_IDLE) begin
      trig_mode_q <= (cal_len_sel == CAL_LEN_TRIG);
      cal_code_q <= cal_len_sel;
      ms_cnt_q <= bat_cal_ms(cal_len_sel);
    end else if (state_q == BAT_RUN && ms_tick && ms_cnt_q != '0) begin
      ms_cnt_q <= ms_cnt_q - MS_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cal_done_o <= 1'b0;
    end else begin
      cal_done_o <= (state_q == BAT_MEAS) && meas_done_i;
    end
  end

  assign cal_busy_o = (state_q != BAT_IDLE);
  assign cal_measure_o = (state_q == BAT_MEAS);

  // ==========================================================
  // Checks
  int unsigned win_len_q;
  int unsigned samp_since_q;
  int unsigned run_len_q;
  int unsigned win_exp_q;
  int unsigned samp_exp_q;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || zc_event_i) begin
      win_len_q <= 0;
      samp_since_q <= 0;
    end else begin
      win_len_q <= zc_window_o ? win_len_q + 1 : 0;
      samp_since_q <= samp_since_q + 1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      win_exp_q <= 0;
      samp_exp_q <= 0;
    end else if (zc_event_i) begin
      win_exp_q <= int'(bat_win_us(crossing_window_sel)) * US_CYCLES;
      samp_exp_q <= int'(bat_samp_us(sample_delay_sel)) * US_CYCLES;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || state_q == BAT_IDLE) begin
      run_len_q <= 0;
    end else if (state_q == BAT_RUN) begin
      run_len_q <= run_len_q + 1;
    end
  end

  AST_WIN_LEN: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $fell(zc_window_o) && !$past(zc_event_i) |-> win_len_q == win_exp_q)
    else $error("crossing window length wrong");

  AST_SAMP_DELAY: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    sample_strobe_o |-> samp_since_q == samp_exp_q)
    else $error("sample delay wrong");

  AST_CAL_TIMED: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(cal_measure_o) && !trig_mode_q |->
      run_len_q == int'(bat_cal_ms(cal_code_q)) * MS_DIV)
    else $error("timed calibration length wrong");

  AST_TRIG_CANCEL: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_q == BAT_RUN && trig_mode_q && sw_trig_i |=> cal_measure_o)
    else $error("software trigger did not end run");

  AST_TRIG_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_q == BAT_RUN && trig_mode_q && !cancel_trig |=> state_q == BAT_RUN)
    else $error("trigger mode ended without trigger");

  AST_MEAS_WAIT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    cal_measure_o && !meas_done_i |=> cal_measure_o && !cal_done_o)
    else $error("measurement phase left early");

  AST_RESET_VALS: assert property (@(posedge ref_clk_i)
    rst_n_i && $past(!rst_n_i) && !$past(reg_wr_i) |-> sample_delay_sel == 2'h3 &&
      crossing_window_sel == 2'h0 && cal_len_sel == 2'h2)
    else $error("field reset values wrong");

  COV_TIMED: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(cal_measure_o) && !trig_mode_q);
  COV_TRIG: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(cal_measure_o) && trig_mode_q);
  COV_STROBE: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    sample_strobe_o);

endmodule : bat_timing

// file: verif/tb.sv
`timescale 1ns/1ps
module tb;
  import bat_pkg::*;
  localparam int MSD = 4;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, zc_event_i = 1'b0;
  logic cal_start_i = 1'b0, sw_trig_i = 1'b0, ext_trig_i = 1'b0, enable_i = 1'b0;
  logic meas_done_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic zc_window_o, sample_strobe_o, cal_busy_o, cal_measure_o, cal_done_o;
  int err_total = 0, total_checks = 0, cycles = 0, wn, sn, sc, k;
  int win_t[4] = '{WIN_US_0, WIN_US_1, WIN_US_2, WIN_US_3};
  int samp_t[4] = '{SAMP_US_0, SAMP_US_1, SAMP_US_2, SAMP_US_3};
  int cal_t[3] = '{CAL_MS_0, CAL_MS_1, CAL_MS_2};
  bat_timing #(.MS_DIV(MSD)) dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .zc_event_i(zc_event_i), .zc_window_o(zc_window_o),
    .sample_strobe_o(sample_strobe_o), .cal_start_i(cal_start_i), .sw_trig_i(sw_trig_i),
    .ext_trig_i(ext_trig_i), .enable_i(enable_i), .meas_done_i(meas_done_i),
    .cal_busy_o(cal_busy_o), .cal_measure_o(cal_measure_o), .cal_done_o(cal_done_o));
  // ==========================================================
  // Clock and run limit
  initial begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      err_total++;
      conclude();
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk({8'h00, reg_rdata_o}, {8'h00, exp});
  endtask : rd
  // Count cycles from the start edge until measurement begins
  task automatic wait_meas(output int n);
    n = 0;
    #1;
    while (cal_measure_o !== 1'b1 && n < 6000) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
  endtask : wait_meas
  task automatic cal_start();
    @(posedge ref_clk_i);
    cal_start_i <= 1'b1;
    @(posedge ref_clk_i);
    cal_start_i <= 1'b0;
    #1;
    chk({15'h0, cal_busy_o}, 16'h1);
  endtask : cal_start
  task automatic cal_finish();
    repeat (5) @(posedge ref_clk_i);
    #1;
    chk({15'h0, cal_measure_o}, 16'h1);
    @(posedge ref_clk_i);
    meas_done_i <= 1'b1;
    @(posedge ref_clk_i);
    meas_done_i <= 1'b0;
    #1;
    chk({13'h0, cal_done_o, cal_busy_o, cal_measure_o}, 16'h4);
    @(posedge ref_clk_i);
    #1;
    chk({15'h0, cal_done_o}, 16'h0);
  endtask : cal_finish
  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd(8'h29, 8'h0c);
    rd(8'h2a, 8'h02);
    rd(8'h30, 8'h00);
    wr(8'h29, 8'hff);
    wr(8'h2a, 8'hfc);
    wr(8'h30, 8'h5a);
    rd(8'h29, 8'hff);
    rd(8'h2a, 8'hfc);
    rd(8'h30, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h29, {4'h0, 2'(3 - i), 2'(i)});
      @(posedge ref_clk_i);
      zc_event_i <= 1'b1;
      @(posedge ref_clk_i);
      zc_event_i <= 1'b0;
      wn = 0;
      sn = -1;
      sc = 0;
      for (int c = 0; c < 10000; c++) begin
        #1;
        if (zc_window_o === 1'b1) wn++;
        if (sample_strobe_o === 1'b1) begin
          sn = c;
          sc++;
        end
        @(posedge ref_clk_i);
      end
      chk(16'(wn), 16'(win_t[i] * US_CYCLES));
      chk(16'(sn), 16'(samp_t[3 - i] * US_CYCLES));
      chk(16'(sc), 16'h1);
    end
    $display("test crossing timing done");
    for (int i = 0; i < 3; i++) begin
      wr(8'h2a, 8'(i));
      cal_start();
      wait_meas(k);
      chk(16'(k), 16'(cal_t[i] * MSD));
      cal_finish();
    end
    $display("test timed calibration done");
    @(posedge ref_clk_i);
    sw_trig_i <= 1'b1;
    @(posedge ref_clk_i);
    sw_trig_i <= 1'b0;
    #1;
    chk({14'h0, cal_busy_o, cal_measure_o}, 16'h0);
    wr(8'h2a, 8'h03);
    for (int t = 0; t < 3; t++) begin
      cal_start();
      repeat (CAL_MS_2 * MSD) @(posedge ref_clk_i);
      #1;
      chk({14'h0, cal_busy_o, cal_measure_o}, 16'h2);
      @(posedge ref_clk_i);
      if (t == 0) sw_trig_i <= 1'b1;
      if (t == 1) ext_trig_i <= 1'b1;
      if (t == 2) enable_i <= 1'b1;
      @(posedge ref_clk_i);
      sw_trig_i <= 1'b0;
      ext_trig_i <= 1'b0;
      enable_i <= 1'b0;
      wait_meas(k);
      chk(16'(k), (t == 0) ? 16'h0 : 16'h2);
      cal_finish();
    end
    $display("test triggered calibration done");
    conclude();
  end
endmodule : tb
